// *** verif/toc_output_control_asserts.sv ***
`timescale 1ns/100ps

module toc_output_control_asserts
   import toc_pkg::*;
(
   input wire logic sys_clk, // Clock
   input wire logic reset, // Reset
   input wire logic [7:0] regAddr, // Address
   input wire logic regIoSpace, // Space
   input wire logic regWrite, // Write
   input wire logic regRead, // Read
   input wire logic [7:0] regWriteData, // Wdata
   input wire logic [7:0] regReadData, // Rdata
   input wire logic regReadValid, // Rvalid
   input wire logic timerTickEnable, // Tick
   input wire logic [7:0] timerCountValue, // Count
   input wire logic countingDown, // Down
   input wire logic [7:0] chanBCompareValue, // Cmp B
   input wire logic waveModeHiBit, // Mode hi
   input wire logic chanAForceMatch, // Force A
   input wire logic chanAPortData, // Port A
   input wire logic chanAWaveOut, // Wave A
   input wire logic chanBWaveOut, // Wave B
   input wire logic chanAPinOut, // Pin A
   input wire logic [2:0] waveModeSelect // Mode
);
   logic [7:0] ctrl;
   logic hit;
   logic pcExpB;
   // Shadow of the control register, from accepted writes
   assign hit = regAddr == (regIoSpace ? CTRL_IO_OFS : CTRL_DATA_OFS);
   assign pcExpB = ctrl[4] ^ countingDown;
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         ctrl <= CTRL_RESET;
      end else if (regWrite && hit) begin
         ctrl <= regWriteData & CTRL_IMPL_MASK;
      end
   end
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (reset);
   property p_rdHit; regRead && hit |=> regReadValid; endproperty
   property p_rdMiss; regRead && !hit |=> !regReadValid; endproperty
   property p_rdData; regReadValid |-> regReadData == $past(ctrl);
   endproperty
   property p_rdIdle; !regReadValid |-> regReadData == READ_IDLE;
   endproperty
   property p_mode; waveModeSelect == {waveModeHiBit, ctrl[1:0]};
   endproperty
   property p_pinA; ctrl[7] |=> chanAPinOut == chanAWaveOut; endproperty
   property p_detA; ctrl[7:6] == MODE_OFF
      |=> chanAPinOut == $past(chanAPortData); endproperty
   property p_holdB; ctrl[5:4] == MODE_OFF |=> $stable(chanBWaveOut);
   endproperty
   property p_noTickA; !timerTickEnable && !chanAForceMatch
      |=> $stable(chanAWaveOut); endproperty
   property p_fastA; waveModeSelect == WM_FAST_MAX && timerTickEnable
      && ctrl[7:6] == MODE_CLEAR && timerCountValue == COUNT_MAX
      |=> chanAWaveOut; endproperty
   property p_pcB; waveModeSelect == WM_PC_MAX && ctrl[5] && timerTickEnable
      && timerCountValue == chanBCompareValue
      && chanBCompareValue != COUNT_MAX
      |=> chanBWaveOut == $past(pcExpB); endproperty
   property p_toggleA; waveModeSelect == WM_NORMAL && chanAForceMatch
      && ctrl[7:6] == MODE_TOGGLE |=> chanAWaveOut != $past(chanAWaveOut);
   endproperty
   a_rdHit: assert property (p_rdHit) else $error("no valid");
   a_rdMiss: assert property (p_rdMiss) else $error("miss valid");
   a_rdData: assert property (p_rdData) else $error("bad data");
   a_rdIdle: assert property (p_rdIdle) else $error("data idle");
   a_mode: assert property (p_mode) else $error("bad mode");
   a_pinA: assert property (p_pinA) else $error("pin not wave");
   a_detA: assert property (p_detA) else $error("pin not port");
   a_holdB: assert property (p_holdB) else $error("B moved");
   a_noTickA: assert property (p_noTickA) else $error("A moved");
   a_fastA: assert property (p_fastA) else $error("no set at wrap");
   a_pcB: assert property (p_pcB) else $error("bad B match");
   a_toggleA: assert property (p_toggleA) else $error("no toggle");
   c_read: cover property (regRead && hit ##1 regReadValid);
   c_fast: cover property (p_fastA);
   c_pc: cover property (p_pcB);
endmodule

bind toc_output_control toc_output_control_asserts
   toc_output_control_asserts_i (
   .sys_clk(sys_clk), .reset(reset), .regAddr(regAddr),
   .regIoSpace(regIoSpace), .regWrite(regWrite), .regRead(regRead),
   .regWriteData(regWriteData), .regReadData(regReadData),
   .regReadValid(regReadValid), .timerTickEnable(timerTickEnable),
   .timerCountValue(timerCountValue), .countingDown(countingDown),
   .chanBCompareValue(chanBCompareValue), .waveModeHiBit(waveModeHiBit),
   .chanAForceMatch(chanAForceMatch), .chanAPortData(chanAPortData),
   .chanAWaveOut(chanAWaveOut), .chanBWaveOut(chanBWaveOut),
   .chanAPinOut(chanAPinOut), .waveModeSelect(waveModeSelect));

// *** verif/toc_output_control_tb.sv ***
`timescale 1ns/100ps

`define CHK(nm, ex, ac) begin checked++; if ((ac) !== (ex)) begin \
   badCount++; $display("wrong value %s exp %0h got %0h", nm, ex, ac); \
   end end

module toc_output_control_tb;
   import toc_pkg::*;
   logic sysClk = 1'b0;
   logic reset = 1'b1;
   logic [7:0] regAddr = 8'h00, regWriteData = 8'h00, cnt = 8'h00;
   logic [7:0] cmpA = 8'h10, cmpB = 8'h20, rdData;
   logic regIoSpace = 0, regWrite = 0, regRead = 0, tick = 0, down = 0;
   logic hiBit = 0, frcA = 0, frcB = 0, dirA = 1, dirB = 1;
   logic portA = 0, portB = 0, rdValid, waveA, waveB;
   logic pinA, oeA, pinB, oeB, lvlA, lvlB;
   logic [2:0] modeSel;
   int badCount = 0, checked = 0, cycles = 0;

   toc_output_control toc_output_control_i (.sys_clk(sysClk), .reset(reset),
      .regAddr(regAddr), .regIoSpace(regIoSpace), .regWrite(regWrite),
      .regRead(regRead), .regWriteData(regWriteData), .regReadData(rdData),
      .regReadValid(rdValid), .timerTickEnable(tick),
      .timerCountValue(cnt), .countingDown(down),
      .chanACompareValue(cmpA), .chanBCompareValue(cmpB),
      .waveModeHiBit(hiBit), .chanAForceMatch(frcA),
      .chanBForceMatch(frcB), .chanADirOut(dirA), .chanBDirOut(dirB),
      .chanAPortData(portA), .chanBPortData(portB), .chanAWaveOut(waveA),
      .chanBWaveOut(waveB), .chanAPinOut(pinA), .chanAPinOe(oeA),
      .chanBPinOut(pinB), .chanBPinOe(oeB), .waveModeSelect(modeSel));
   toc_pin_load toc_pin_load_i (.pinAOut(pinA), .pinAOe(oeA),
      .pinBOut(pinB), .pinBOe(oeB), .levelA(lvlA), .levelB(lvlB));

   // Clock and hang guard; the whole run needs well under 400 cycles
   always #20 sysClk = ~sysClk;
   always @(posedge sysClk) begin
      cycles++;
      if (cycles == 2000) begin
         badCount++;
         final_report;
      end
   end

   task step;
      @(posedge sysClk);
      #1;
   endtask
   task wr(input logic [7:0] a, input logic io, input logic [7:0] d);
      step;
      {regAddr, regIoSpace, regWriteData, regWrite} = {a, io, d, 1'b1};
      step;
      regWrite = 0;
   endtask
   task rd(input logic [7:0] a, input logic io, input logic v,
      input logic [7:0] e);
      step;
      {regAddr, regIoSpace, regRead} = {a, io, 1'b1};
      step;
      regRead = 0;
      `CHK("read valid", v, rdValid)
      `CHK("read data", e, rdData)
   endtask
   // One event cycle; outputs are judged one edge later
   task ev(input logic [7:0] c, input logic d, input logic t,
      input logic fa, input logic fb);
      step;
      {cnt, down, tick, frcA, frcB} = {c, d, t, fa, fb};
      step;
      {tick, frcA, frcB} = 3'h0;
   endtask
   task chkW(input logic ea, input logic eb);
      `CHK("wave A", ea, waveA)
      `CHK("wave B", eb, waveB)
   endtask

   task t_regs;
      rd(8'h44, 0, 1, 8'h00);
      wr(8'h24, 1, 8'hff);
      rd(8'h44, 0, 1, 8'hf3);
      wr(8'h45, 0, 8'h00);
      rd(8'h24, 1, 1, 8'hf3);
      rd(8'h44, 1, 0, 8'h00);
      $display("test regs done");
   endtask
   task t_nonpwm;
      logic [1:0] codes [6];
      logic e;
      codes = '{2'h1, 2'h2, 2'h3, 2'h1, 2'h3, 2'h0};
      e = 0;
      for (int i = 0; i < 6; i++) begin
         wr(8'h44, 0, {codes[i], codes[i], 4'h0});
         ev(8'h00, 0, 0, 1, 1);
         if (codes[i] == 2'h1) e = ~e;
         else if (codes[i] != 2'h0) e = codes[i][0];
         chkW(e, e);
         `CHK("pin A", codes[i] != 0 ? e : portA, lvlA)
         `CHK("pin B", codes[i] != 0 ? e : portB, lvlB)
      end
      dirA = 0;
      step;
      step;
      `CHK("pin A enable", 1'b0, oeA)
      `CHK("pin A float", 1'b1, lvlA)
      dirA = 1;
      $display("test nonpwm done");
   endtask
   // Code 01 is never written to channel B in PWM
   task t_fast;
      wr(8'h44, 0, 8'hb3);
      `CHK("mode", 3'h3, modeSel)
      ev(8'hff, 0, 1, 0, 0);
      chkW(1, 0);
      ev(8'h10, 0, 1, 0, 0);
      chkW(0, 0);
      ev(8'h20, 0, 0, 0, 0);
      chkW(0, 0);
      ev(8'h20, 0, 1, 0, 0);
      chkW(0, 1);
      {cmpA, cmpB} = 16'hffff;
      ev(8'hff, 0, 1, 0, 0);
      chkW(1, 0);
      $display("test fast done");
   endtask
   task t_pc;
      {cmpA, cmpB} = 16'h4040;
      wr(8'h44, 0, 8'hb1);
      ev(8'h40, 0, 1, 0, 0);
      chkW(0, 1);
      ev(8'h40, 1, 1, 0, 0);
      chkW(1, 0);
      ev(8'h40, 0, 1, 0, 0);
      chkW(0, 1);
      cmpA = 8'hff;
      ev(8'hff, 0, 1, 0, 0);
      chkW(1, 1);
      $display("test pc done");
   endtask
   task t_toggle;
      {hiBit, cmpA} = {1'b1, 8'h30};
      wr(8'h44, 0, 8'h41);
      `CHK("mode", 3'h5, modeSel)
      ev(8'h30, 0, 1, 0, 0);
      chkW(0, 1);
      ev(8'h30, 1, 1, 0, 0);
      chkW(1, 1);
      `CHK("pin A", 1'b1, lvlA)
      hiBit = 0;
      ev(8'h30, 0, 1, 0, 0);
      chkW(1, 1);
      `CHK("pin A", portA, lvlA)
      $display("test toggle done");
   endtask

   task final_report;
      $display("checks %0d mismatches %0d", checked, badCount);
      if (badCount == 0 && checked > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   initial begin
      repeat (5) @(posedge sysClk);
      #1 reset = 0;
      t_regs;
      t_nonpwm;
      t_fast;
      t_pc;
      t_toggle;
      final_report;
   end
endmodule

// *** verif/toc_pin_load.sv ***
`timescale 1ns/100ps

module toc_pin_load (
   input wire logic pinAOut, // Pin A value
   input wire logic pinAOe, // Pin A enable
   input wire logic pinBOut, // Pin B value
   input wire logic pinBOe, // Pin B enable
   output logic levelA, // Wire level A
   output logic levelB // Wire level B
);
   // Board pull-ups: an undriven pin reads high
   assign levelA = pinAOe ? pinAOut : 1'b1;
   assign levelB = pinBOe ? pinBOut : 1'b1;
endmodule

// *** verilog/toc_output_control.sv ***
`timescale 1ns/100ps

// Notes on behaviour
// - Synchronous on base clock, tick is enable
// - Async-capable instance still runs on base clock
// - Nonzero A mode gives pin to waveform, but 01 in PWM needs high bit
// - Non-PWM A: off, toggle, clear, set
// - PWM A toggle needs high mode bit
// - Fast PWM A: match and BOTTOM actions
// - Fast PWM A compare at TOP ignored for codes 10 and 11; toggle still acts on it
// - Phase correct A: direction picks action
// - Phase correct A compare at TOP acts at TOP
// - Nonzero B mode gives pin to waveform, except 01 in PWM
// - Non-PWM B: off, toggle, clear, set
// - Fast PWM B actions; code 01 reserved
// - Phase correct B actions; code 01 reserved
// - Fast PWM B compare at TOP ignored; phase correct B acts at TOP
// - Fields: A 7:6, B 5:4, wave 1:0
// - Register at 0x44, I/O space 0x24
// - Reset clears every implemented control bit
// - Three-bit waveform mode decode table
// - Mode high bit comes from elsewhere

module toc_output_control
   import toc_pkg::*;
#(
   parameter bit ASYNC_CAPABLE = 1'b0 // Oscillator mode flag, unused; clock is always base clock
)
(
   input wire logic sys_clk, // Base clock
   input wire logic reset, // Synchronous, active high
   input wire logic [7:0] regAddr, // Register address
   input wire logic regIoSpace, // 1: I/O space address
   input wire logic regWrite, // Write strobe
   input wire logic regRead, // Read strobe
   input wire logic [7:0] regWriteData, // Write data
   output logic [7:0] regReadData, // Read data, one cycle later
   output logic regReadValid, // Read data valid pulse
   input wire logic timerTickEnable, // Timer clock enable
   input wire logic [7:0] timerCountValue, // Counter value
   input wire logic countingDown, // Counter direction
   input wire logic [7:0] chanACompareValue, // Channel A compare
   input wire logic [7:0] chanBCompareValue, // Channel B compare
   input wire logic waveModeHiBit, // Upper waveform mode bit
   input wire logic chanAForceMatch, // Forced match strobe, A
   input wire logic chanBForceMatch, // Forced match strobe, B
   input wire logic chanADirOut, // Pin direction bit, A
   input wire logic chanBDirOut, // Pin direction bit, B
   input wire logic chanAPortData, // Port data for pin A
   input wire logic chanBPortData, // Port data for pin B
   output logic chanAWaveOut, // Waveform bit, A
   output logic chanBWaveOut, // Waveform bit, B
   output logic chanAPinOut, // Pin value, A
   output logic chanAPinOe, // Pin enable, A
   output logic chanBPinOut, // Pin value, B
   output logic chanBPinOe, // Pin enable, B
   output logic [2:0] waveModeSelect // Combined waveform mode
);

   typedef struct packed {
      logic [7:0] ctrl;
      logic [7:0] readData;
      logic readValid;
   } toc_ctrl_state_type;

   toc_ctrl_state_type state;
   toc_ctrl_state_type next_state;

   logic [1:0] chanAOutputMode;
   logic [1:0] chanBOutputMode;
   logic chanAOutputModeHi;
   logic chanBOutputModeHi;
   toc_wave_mode_type waveMode;
   logic [7:0] topValue;
   logic regHit;
   logic wrapTop;
   logic chanAMatch;
   logic chanBMatch;
   logic chanACmpIsTop;
   logic chanBCmpIsTop;
   logic chanAConnected;
   logic chanBConnected;
   toc_action_type chanAAction;
   toc_action_type chanBAction;

   // True for either PWM family
   function automatic logic is_pwm(
      input toc_wave_mode_type mode
   );
      logic pwm;
      pwm = 1'b0;
      case (mode)
         WM_PC_MAX, WM_PC_CMP, WM_FAST_MAX, WM_FAST_CMP: pwm = 1'b1;
         default: pwm = 1'b0;
      endcase
      return pwm;
   endfunction

   // Does the waveform own the pin for this code and mode
   function automatic logic chan_connected(
      input logic [1:0] code,
      input logic isA,
      input toc_wave_mode_type mode,
      input logic hiBit
   );
      logic conn;
      conn = (code != MODE_OFF);
      // Toggle code in PWM only exists on A with high bit
      if (is_pwm(mode) && code == MODE_TOGGLE && !(isA && hiBit)) begin
         conn = 1'b0; // Reserved on B, treated as detached
      end
      return conn;
   endfunction

   // Output action of one channel for this cycle
   function automatic toc_action_type chan_action(
      input logic [1:0] code,
      input logic isA,
      input toc_wave_mode_type mode,
      input logic hiBit,
      input logic match,
      input logic forced,
      input logic wrapTop,
      input logic down,
      input logic cmpIsTop
   );
      logic special;
      logic upSense;
      toc_action_type act;
      act = ACT_HOLD;
      special = code[1] && cmpIsTop;
      upSense = (code == MODE_CLEAR) ^ down;
      case (mode)
         WM_FAST_MAX, WM_FAST_CMP: begin
            if (code == MODE_TOGGLE) begin
               if (isA && hiBit && match) begin
                  act = ACT_TOGGLE;
               end
            end else if (code[1]) begin
               // Wrap to BOTTOM wins; compare at TOP is dropped
               if (wrapTop) begin
                  // Non-inverting sets, inverting clears
                  act = (code == MODE_CLEAR) ? ACT_SET : ACT_CLEAR;
               end else if (match && !special) begin
                  act = (code == MODE_CLEAR) ? ACT_CLEAR : ACT_SET;
               end
            end
         end
         WM_PC_MAX, WM_PC_CMP: begin
            if (code == MODE_TOGGLE) begin
               if (isA && hiBit && match) begin
                  act = ACT_TOGGLE;
               end
            end else if (code[1]) begin
               if (special) begin
                  // Compare at TOP: act once at TOP
                  if (wrapTop) begin
                     act = (code == MODE_CLEAR) ? ACT_SET : ACT_CLEAR;
                  end
               end else if (match) begin
                  // Up clears for code 10, down sets
                  act = upSense ? ACT_CLEAR : ACT_SET;
               end
            end
         end
         default: begin
            // Normal, CTC and reserved codes; force is honoured here only
            if (match || forced) begin
               case (code)
                  MODE_TOGGLE: act = ACT_TOGGLE;
                  MODE_CLEAR: act = ACT_CLEAR;
                  MODE_SET: act = ACT_SET;
                  default: act = ACT_HOLD;
               endcase
            end
         end
      endcase
      return act;
   endfunction

   // Field extraction from the control register
   assign chanAOutputMode = state.ctrl[CHA_MODE_HI:CHA_MODE_LO];
   assign chanBOutputMode = state.ctrl[CHB_MODE_HI:CHB_MODE_LO];
   assign chanAOutputModeHi = state.ctrl[CHA_MODE_HI];
   assign chanBOutputModeHi = state.ctrl[CHB_MODE_HI];

   // High bit lives in the other control register
   assign waveMode = toc_wave_mode_type'(
      {waveModeHiBit, state.ctrl[WAVE_SEL_HI:WAVE_SEL_LO]});
   assign waveModeSelect = waveMode;

   // TOP per mode; CTC uses compare A, reserved and Normal fall back to MAX
   always_comb begin
      case (waveMode)
         WM_PC_CMP, WM_FAST_CMP: topValue = chanACompareValue;
         WM_CTC: topValue = chanACompareValue;
         default: topValue = COUNT_MAX;
      endcase
   end

   // Events count only on timer ticks
   assign wrapTop = timerTickEnable && (timerCountValue == topValue);
   assign chanAMatch = timerTickEnable
      && (timerCountValue == chanACompareValue);
   assign chanBMatch = timerTickEnable
      && (timerCountValue == chanBCompareValue);

   // Special case needs the upper mode bit as well
   assign chanACmpIsTop = chanAOutputModeHi
      && (chanACompareValue == topValue);
   assign chanBCmpIsTop = chanBOutputModeHi
      && (chanBCompareValue == topValue);

   // Pin ownership per channel
   assign chanAConnected = chan_connected(chanAOutputMode, 1'b1,
      waveMode, waveModeHiBit);
   assign chanBConnected = chan_connected(chanBOutputMode, 1'b0,
      waveMode, waveModeHiBit);

   // Per-channel actions, same decode for both
   assign chanAAction = chan_action(chanAOutputMode, 1'b1, waveMode,
      waveModeHiBit, chanAMatch, chanAForceMatch, wrapTop,
      countingDown, chanACmpIsTop);
   assign chanBAction = chan_action(chanBOutputMode, 1'b0, waveMode,
      waveModeHiBit, chanBMatch, chanBForceMatch, wrapTop,
      countingDown, chanBCmpIsTop);

   // Address decode: data space or shifted I/O space
   assign regHit = regIoSpace ? (regAddr == CTRL_IO_OFS)
      : (regAddr == CTRL_DATA_OFS);

   // Register writes and registered read data
   always_comb begin
      next_state = state;
      next_state.readValid = regRead && regHit;
      // Unselected reads return zero so a shared bus can OR them
      next_state.readData = READ_IDLE;
      if (regRead && regHit) begin
         next_state.readData = state.ctrl;
      end
      // Bits 3:2 are not stored and read as zero
      if (regWrite && regHit) begin
         next_state.ctrl = regWriteData & CTRL_IMPL_MASK;
      end
   end

   // Whole base-clock domain, async-capable instances included
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         state.ctrl <= CTRL_RESET;
         state.readData <= READ_IDLE;
         state.readValid <= 1'b0;
      end else begin
         state <= next_state;
      end
   end

   assign regReadData = state.readData;
   assign regReadValid = state.readValid;

   // Channel A output stage
   toc_wave_channel chanAUnit (
      .sys_clk(sys_clk),
      .reset(reset),
      .action(chanAAction),
      .connected(chanAConnected),
      .dirOut(chanADirOut),
      .portData(chanAPortData),
      .waveOut(chanAWaveOut),
      .pinOut(chanAPinOut),
      .pinOe(chanAPinOe)
   );

   // Channel B output stage
   toc_wave_channel chanBUnit (
      .sys_clk(sys_clk),
      .reset(reset),
      .action(chanBAction),
      .connected(chanBConnected),
      .dirOut(chanBDirOut),
      .portData(chanBPortData),
      .waveOut(chanBWaveOut),
      .pinOut(chanBPinOut),
      .pinOe(chanBPinOe)
   );

endmodule

// *** verilog/toc_pkg.sv ***
package toc_pkg;

   // Register placement on the data and I/O address spaces
   localparam logic [7:0] CTRL_DATA_OFS = 8'h44;
   localparam logic [7:0] IO_SPACE_SHIFT = 8'h20;
   localparam logic [7:0] CTRL_IO_OFS = CTRL_DATA_OFS - IO_SPACE_SHIFT;

   // Field layout of the output mode control register
   localparam int CHA_MODE_HI = 7;
   localparam int CHA_MODE_LO = 6;
   localparam int CHB_MODE_HI = 5;
   localparam int CHB_MODE_LO = 4;
   localparam int WAVE_SEL_HI = 1;
   localparam int WAVE_SEL_LO = 0;
   localparam logic [7:0] CTRL_IMPL_MASK = 8'hf3;
   localparam logic [7:0] CTRL_RESET = 8'h00;
   localparam logic [7:0] READ_IDLE = 8'h00;

   // Counter landmarks
   localparam logic [7:0] COUNT_BOTTOM = 8'h00;
   localparam logic [7:0] COUNT_MAX = 8'hff;

   // Output mode codes of one channel
   localparam logic [1:0] MODE_OFF = 2'h0;
   localparam logic [1:0] MODE_TOGGLE = 2'h1;
   localparam logic [1:0] MODE_CLEAR = 2'h2;
   localparam logic [1:0] MODE_SET = 2'h3;

   // Three-bit waveform mode
   typedef enum logic [2:0] {
      WM_NORMAL = 3'h0,
      WM_PC_MAX = 3'h1,
      WM_CTC = 3'h2,
      WM_FAST_MAX = 3'h3,
      WM_RSV4 = 3'h4,
      WM_PC_CMP = 3'h5,
      WM_RSV6 = 3'h6,
      WM_FAST_CMP = 3'h7
   } toc_wave_mode_type;

   // What one channel does to its output this cycle
   typedef enum logic [1:0] {
      ACT_HOLD = 2'h0,
      ACT_TOGGLE = 2'h1,
      ACT_CLEAR = 2'h2,
      ACT_SET = 2'h3
   } toc_action_type;

endpackage

// *** verilog/toc_wave_channel.sv ***
`timescale 1ns/100ps

module toc_wave_channel
   import toc_pkg::*;
(
   input wire logic sys_clk, // Base clock
   input wire logic reset, // Synchronous, active high
   input wire toc_action_type action, // Output action this cycle
   input wire logic connected, // Waveform owns the pin
   input wire logic dirOut, // Port direction bit, 1 = output
   input wire logic portData, // Ordinary port data
   output logic waveOut, // Internal waveform bit
   output logic pinOut, // Pin output value
   output logic pinOe // Pin output enable
);

   typedef struct packed {
      logic wave;
      logic pinOut;
      logic pinOe;
   } toc_chan_state_type;

   toc_chan_state_type state;
   toc_chan_state_type next_state;

   // Apply the action, then steer the pin
   always_comb begin
      next_state = state;
      // A detached channel freezes so it resumes cleanly
      if (connected) begin
         case (action)
            ACT_TOGGLE: next_state.wave = ~state.wave;
            ACT_CLEAR: next_state.wave = 1'b0;
            ACT_SET: next_state.wave = 1'b1;
            default: next_state.wave = state.wave;
         endcase
      end
      // Waveform replaces port data, driver still needs dir
      next_state.pinOut = connected ? next_state.wave : portData;
      next_state.pinOe = dirOut;
   end

   // Single state register
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         state <= '0;
      end else begin
         state <= next_state;
      end
   end

   assign waveOut = state.wave;
   assign pinOut = state.pinOut;
   assign pinOe = state.pinOe;

endmodule
